/* bsti_ctl_model.sv */
`timescale 1ns/1ps
// ============================================================
// Board-level scan controller. Its clock stands still between frames.
module bsti_ctl_model (
	// Test port towards the device.
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// Idle levels follow the pull-ups on the mode and data lines.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One test clock period. A released data line reads as unknown, so it never matches.
	task automatic pulse(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#16;
		q = (tdo_oe === 1'b1) ? tdo : 1'bx;
		tck = 1'b1;
		#16;
		tck = 1'b0;
	endtask

	// Walk the controller with a mode sequence, first step in bit 0.
	task automatic steps(input logic [7:0] seq, input int n);
		logic q;
		for (int i = 0; i < n; i++) begin
			pulse(seq[i], 1'b1, q);
		end
	endtask

	// Shift n bits in Shift state; data enters at the top and leaves bit 0 first.
	task automatic shift(input int n, input logic [107:0] din, output logic [107:0] dout);
		logic q;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			pulse(i == n - 1, din[i], q);
			dout[i] = q;
		end
	endtask

	// Full data scan from idle back to idle, passing through the update state.
	task automatic scan_dr(input int n, input logic [107:0] din, output logic [107:0] dout);
		steps(8'h01, 3);
		shift(n, din, dout);
		steps(8'h01, 2);
	endtask

	// Full instruction scan from idle back to idle; returns the captured pattern.
	task automatic scan_ir(input logic [2:0] code, output logic [2:0] cap);
		logic [107:0] o;
		steps(8'h03, 4);
		shift(3, {105'h0, code}, o);
		steps(8'h01, 2);
		cap = o[2:0];
	endtask

	// Five high mode edges reach the reset state, then one low edge to idle.
	task automatic tap_reset();
		steps(8'h1f, 5);
		steps(8'h00, 1);
	endtask
endmodule

/* bsti_fsm.sv */
`timescale 1ns/1ps
// ============================================================
// Sixteen-state test controller, advanced by the mode select line.
module bsti_fsm
	import bsti_pkg::*;
(
	// Link side.
	input wire logic tck,
	input wire logic reset_n,
	input wire logic tms,
	// State towards the scan registers.
	bsti_tap_if.ctrl tap
);

	bsti_state_type state_reg;
	bsti_state_type state_next;
	logic [2:0] ones_reg;
	logic [2:0] ones_next;

	// Next state; power-up puts the controller in test-logic-reset.
	always_comb begin
		ones_next = tms ? ((ones_reg == 3'h7) ? ones_reg : ones_reg + 3'h1) : 3'h0;
		case (state_reg)
			ST_TLR: state_next = tms ? ST_TLR : ST_RTI;
			ST_RTI: state_next = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_next = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: state_next = tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_next = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_RTI;
			default: state_next = ST_TLR;
		endcase
	end

	// State register; the ones counter only feeds the check below.
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_TLR;
			ones_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			ones_reg <= ones_next;
		end
	end

	assign tap.state = state_reg;

	// ============================================================
	// Checks.
	property p_five_ones;
		@(posedge tck) disable iff (!reset_n)
		(ones_reg >= 3'(TLR_TMS_COUNT)) |-> (state_reg == ST_TLR);
	endproperty
	a_five_ones: assert property (p_five_ones) else $error("Five high TMS did not reset.");

	property p_tlr_leave;
		@(posedge tck) disable iff (!reset_n)
		(state_reg == ST_TLR) && !tms |=> (state_reg == ST_RTI);
	endproperty
	a_tlr_leave: assert property (p_tlr_leave) else $error("Reset state left wrongly.");

endmodule

/* bsti_pkg.sv */
// ============================================================
// Shared constants of the boundary scan test access port.
package bsti_pkg;

	// ============================================================
	// Scan register lengths.
	localparam int IR_LEN = 3;
	localparam int ID_LEN = 32;
	localparam int BSR_LEN = 107;

	// ============================================================
	// Instruction codes; the three unnamed codes are reserved.
	localparam logic [2:0] OP_EXTEST = 3'h0;
	localparam logic [2:0] OP_IDCODE = 3'h1;
	localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
	localparam logic [2:0] OP_SAMPLE = 3'h4;
	localparam logic [2:0] OP_BYPASS = 3'h7;

	// ============================================================
	// Capture patterns, reset values and field positions.
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam logic [2:0] IR_RESET = OP_IDCODE;
	localparam logic BYPASS_CAPTURE = 1'b0;
	localparam int OE_CELL = 47;
	localparam logic OE_CELL_RESET = 1'b1;
	localparam logic [106:0] BSR_UPD_RESET = 107'h1 << OE_CELL;
	localparam int ID_REV_LSB = 29;
	localparam int ID_DEV_LSB = 12;
	localparam int ID_VEN_LSB = 1;
	localparam logic ID_PRESENT = 1'b1;
	localparam int TLR_TMS_COUNT = 5;

	// ============================================================
	// Controller states, Gray coded in the order listed.
	typedef enum logic [3:0] {
		ST_TLR = 4'h0,
		ST_RTI = 4'h1,
		ST_SEL_DR = 4'h3,
		ST_CAP_DR = 4'h2,
		ST_SH_DR = 4'h6,
		ST_EX1_DR = 4'h7,
		ST_PAU_DR = 4'h5,
		ST_EX2_DR = 4'h4,
		ST_UPD_DR = 4'hc,
		ST_SEL_IR = 4'hd,
		ST_CAP_IR = 4'hf,
		ST_SH_IR = 4'he,
		ST_EX1_IR = 4'ha,
		ST_PAU_IR = 4'hb,
		ST_EX2_IR = 4'h9,
		ST_UPD_IR = 4'h8
	} bsti_state_type;

endpackage

/* bsti_tap_if.sv */
`timescale 1ns/1ps
// ============================================================
// Controller state as seen by the scan registers.
interface bsti_tap_if;
	import bsti_pkg::*;
	bsti_state_type state;
	modport ctrl (output state);
	modport user (input state);
endinterface

/* bsti_top.sv */
`timescale 1ns/1ps
// Behaviour
// - Identification instruction loads at reset and test-logic-reset.
// - Outputs-off sampling shifts boundary register in Shift-DR.
// - Outputs-off sampling holds read bus high impedance.
// - Sample/preload captures pin values in Capture-DR.
// - Captured sample shifts out through boundary register.
// - Update-DR moves shifted data to latched outputs.
// - Preload shifts in while sample shifts out.
// - Bypass puts one-bit register between TDI, TDO.
// - External test drives preloaded values and shifts boundary.
// - Cell 47 latch controls read bus under external test.
// - Cell 47 one drives, zero floats read bus.
// - Cell 47 presets to one at reset.
// - Identification fields: revision, device type, vendor.
// - Identification bit zero always reads one.
// - Lengths: instruction 3, bypass 1, id 32, boundary 107.
// - Instruction codes decode as the fixed table.
// - Five high TMS edges reset the test logic.
// - Capture-IR loads low instruction bits with 01.
// - Sample on TCK rise, TDO changes on fall.
module bsti_top
	import bsti_pkg::*;
#(
	parameter logic [2:0] ID_REVISION = 3'h1, // Arbitrary value.
	parameter logic [16:0] ID_DEVICE = 17'h0a5a5, // Arbitrary value.
	parameter logic [10:0] ID_VENDOR = 11'h2aa // Arbitrary value.
)
(
	// Core clock and power-up reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Test port.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// Pin ring towards the memory core.
	input wire logic [106:0] pin_values,
	input wire logic core_q_oe,
	output logic pin_drive_en,
	output logic [106:0] pin_drive_val,
	output logic q_bus_oe
);

	localparam logic [31:0] ID_VALUE = {ID_REVISION, ID_DEVICE, ID_VENDOR, ID_PRESENT};

	bsti_tap_if tap ();

	bsti_fsm u_fsm (
		.tck(tck),
		.reset_n(reset_n),
		.tms(tms),
		.tap(tap.ctrl)
	);

	// ============================================================
	// Test clock domain: scan registers.
	logic [106:0] pin_meta_reg;
	logic [106:0] pin_sync_reg;
	logic [2:0] ir_shift_reg;
	logic [2:0] ir_shift_next;
	logic [2:0] ir_reg;
	logic [2:0] ir_next;
	logic bypass_reg;
	logic bypass_next;
	logic [31:0] id_shift_reg;
	logic [31:0] id_shift_next;
	logic [106:0] bsr_shift_reg;
	logic [106:0] bsr_shift_next;
	logic [106:0] bsr_upd_reg;
	logic [106:0] bsr_upd_next;
	logic xfer_tgl_reg;
	logic xfer_tgl_next;
	logic tdo_src;
	logic tdo_en_src;
	logic sel_bsr;
	logic sel_id;
	bsti_state_type st;

	assign st = tap.state;

	// Register selection; reserved codes fall back to bypass so the chain stays short.
	always_comb begin
		sel_bsr = (ir_reg == OP_EXTEST) || (ir_reg == OP_SAMPLE_Z) || (ir_reg == OP_SAMPLE);
		sel_id = (ir_reg == OP_IDCODE);
	end

	// Pin ring arrives from the core clock, so it passes two flops first.
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= pin_values;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Next values of all scan registers, stepped by the controller state.
	always_comb begin
		ir_shift_next = ir_shift_reg;
		ir_next = ir_reg;
		bypass_next = bypass_reg;
		id_shift_next = id_shift_reg;
		bsr_shift_next = bsr_shift_reg;
		bsr_upd_next = bsr_upd_reg;
		case (st)
			ST_TLR: begin
				ir_next = IR_RESET;
				bsr_upd_next[OE_CELL] = OE_CELL_RESET;
			end
			ST_CAP_IR: ir_shift_next = IR_CAPTURE;
			ST_SH_IR: ir_shift_next = {tdi, ir_shift_reg[2:1]};
			ST_UPD_IR: ir_next = ir_shift_reg;
			ST_CAP_DR: begin
				if (sel_bsr) begin
					bsr_shift_next = pin_sync_reg;
				end else if (sel_id) begin
					id_shift_next = ID_VALUE;
				end else begin
					bypass_next = BYPASS_CAPTURE;
				end
			end
			ST_SH_DR: begin
				if (sel_bsr) begin
					bsr_shift_next = {tdi, bsr_shift_reg[106:1]};
				end else if (sel_id) begin
					id_shift_next = {tdi, id_shift_reg[31:1]};
				end else begin
					bypass_next = tdi;
				end
			end
			ST_UPD_DR: begin
				if (sel_bsr) begin
					bsr_upd_next = bsr_shift_reg;
				end
			end
			default: begin
			end
		endcase
		// Any change of mode or latched cells is announced to the core by a toggle.
		xfer_tgl_next = xfer_tgl_reg ^ ((ir_next != ir_reg) || (bsr_upd_next != bsr_upd_reg));
	end

	// Scan registers on the rising test clock edge.
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			ir_shift_reg <= IR_RESET;
			ir_reg <= IR_RESET;
			bypass_reg <= BYPASS_CAPTURE;
			id_shift_reg <= '0;
			bsr_shift_reg <= '0;
			bsr_upd_reg <= BSR_UPD_RESET;
			xfer_tgl_reg <= 1'b0;
		end else begin
			ir_shift_reg <= ir_shift_next;
			ir_reg <= ir_next;
			bypass_reg <= bypass_next;
			id_shift_reg <= id_shift_next;
			bsr_shift_reg <= bsr_shift_next;
			bsr_upd_reg <= bsr_upd_next;
			xfer_tgl_reg <= xfer_tgl_next;
		end
	end

	// Serial output source: low bit of whichever register is selected.
	always_comb begin
		tdo_src = 1'b0;
		tdo_en_src = 1'b0;
		if (st == ST_SH_IR) begin
			tdo_src = ir_shift_reg[0];
			tdo_en_src = 1'b1;
		end else if (st == ST_SH_DR) begin
			tdo_en_src = 1'b1;
			if (sel_bsr) begin
				tdo_src = bsr_shift_reg[0];
			end else if (sel_id) begin
				tdo_src = id_shift_reg[0];
			end else begin
				tdo_src = bypass_reg;
			end
		end
	end

	// Falling edge launch gives the far end half a period of hold margin.
	always_ff @(negedge tck or negedge reset_n) begin
		if (!reset_n) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= tdo_src;
			tdo_oe <= tdo_en_src;
		end
	end

	// ============================================================
	// Core clock domain: mode and preload values applied to the pins.
	logic tgl_meta_reg;
	logic tgl_sync_reg;
	logic tgl_seen_reg;
	logic [2:0] mode_reg;
	logic [2:0] mode_next;
	logic [106:0] val_reg;
	logic [106:0] val_next;
	logic drive_en_next;
	logic q_oe_next;

	// The words are read only after the toggle settles; they change at most
	// once per update or test-logic-reset state, far slower than this domain's three-cycle latency.
	always_comb begin
		mode_next = mode_reg;
		val_next = val_reg;
		if (tgl_sync_reg != tgl_seen_reg) begin
			mode_next = ir_reg;
			val_next = bsr_upd_reg;
		end
		drive_en_next = (mode_reg == OP_EXTEST);
		if (mode_reg == OP_SAMPLE_Z) begin
			q_oe_next = 1'b0;
		end else if (mode_reg == OP_EXTEST) begin
			q_oe_next = val_reg[OE_CELL];
		end else begin
			q_oe_next = core_q_oe;
		end
	end

	// Core side registers; the pin and read bus outputs come straight from here.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tgl_meta_reg <= 1'b0;
			tgl_sync_reg <= 1'b0;
			tgl_seen_reg <= 1'b0;
			mode_reg <= IR_RESET;
			val_reg <= BSR_UPD_RESET;
			pin_drive_en <= 1'b0;
			pin_drive_val <= BSR_UPD_RESET;
			q_bus_oe <= 1'b0;
		end else begin
			tgl_meta_reg <= xfer_tgl_reg;
			tgl_sync_reg <= tgl_meta_reg;
			tgl_seen_reg <= tgl_sync_reg;
			mode_reg <= mode_next;
			val_reg <= val_next;
			pin_drive_en <= drive_en_next;
			pin_drive_val <= val_reg;
			q_bus_oe <= q_oe_next;
		end
	end

	// ============================================================
	// Checks in the test clock domain.
	property p_tlr_ir;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_TLR) |=> (ir_reg == OP_IDCODE) && bsr_upd_reg[OE_CELL];
	endproperty
	a_tlr_ir: assert property (p_tlr_ir) else $error("Reset state did not restore defaults.");

	property p_cap_ir;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_CAP_IR) |=> (ir_shift_reg[1:0] == 2'b01);
	endproperty
	a_cap_ir: assert property (p_cap_ir) else $error("Capture-IR pattern wrong.");

	property p_ir_hold;
		@(posedge tck) disable iff (!reset_n)
		(st != ST_UPD_IR) && (st != ST_TLR) |=> (ir_reg == $past(ir_reg));
	endproperty
	a_ir_hold: assert property (p_ir_hold) else $error("Instruction changed outside update.");

	property p_id_cap;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_CAP_DR) && (ir_reg == OP_IDCODE) |=> (id_shift_reg == ID_VALUE) && id_shift_reg[0];
	endproperty
	a_id_cap: assert property (p_id_cap) else $error("Identification capture wrong.");

	property p_bsr_cap;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_CAP_DR) && (ir_reg == OP_SAMPLE) |=> (bsr_shift_reg == $past(pin_sync_reg));
	endproperty
	a_bsr_cap: assert property (p_bsr_cap) else $error("Sample capture wrong.");

	property p_bsr_shift;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_SH_DR) && sel_bsr |=>
			(bsr_shift_reg == {$past(tdi), $past(bsr_shift_reg[106:1])});
	endproperty
	a_bsr_shift: assert property (p_bsr_shift) else $error("Boundary shift wrong.");

	property p_bsr_out;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_SH_DR) && sel_bsr |-> (tdo == bsr_shift_reg[0]) && tdo_oe;
	endproperty
	a_bsr_out: assert property (p_bsr_out) else $error("Boundary register not on TDO.");

	property p_bypass;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_SH_DR) && (ir_reg == OP_BYPASS) ##1 (st == ST_SH_DR) |->
			(tdo == $past(tdi));
	endproperty
	a_bypass: assert property (p_bypass) else $error("Bypass not one bit long.");

	property p_update;
		@(posedge tck) disable iff (!reset_n)
		(st == ST_UPD_DR) && sel_bsr |=> (bsr_upd_reg == $past(bsr_shift_reg));
	endproperty
	a_update: assert property (p_update) else $error("Update-DR did not latch.");

	// Checks in the core clock domain.
	property p_sample_z;
		@(posedge core_clk) disable iff (!reset_n)
		(mode_reg == OP_SAMPLE_Z) |=> !q_bus_oe;
	endproperty
	a_sample_z: assert property (p_sample_z) else $error("Read bus driven while off.");

	property p_extest_oe;
		@(posedge core_clk) disable iff (!reset_n)
		(mode_reg == OP_EXTEST) |=> (q_bus_oe == $past(val_reg[OE_CELL])) && pin_drive_en;
	endproperty
	a_extest_oe: assert property (p_extest_oe) else $error("Cell 47 not steering bus.");

	c_extest: cover property (@(posedge core_clk) disable iff (!reset_n) pin_drive_en && !q_bus_oe);
	c_preload: cover property (@(posedge tck) disable iff (!reset_n)
		(st == ST_UPD_DR) && (ir_reg == OP_SAMPLE));
	c_bypass: cover property (@(posedge tck) disable iff (!reset_n)
		(st == ST_SH_DR) && (ir_reg == OP_BYPASS));
	c_idcode: cover property (@(posedge tck) disable iff (!reset_n)
		(st == ST_SH_DR) && sel_id);

endmodule

/* bsti_top_test.sv */
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the scan port against a controller model.
module bsti_top_test;
	import bsti_pkg::*;
	localparam logic [2:0] REV = 3'h5; // Arbitrary value.
	localparam logic [16:0] DEV = 17'h1c3a7; // Arbitrary value.
	localparam logic [10:0] VEN = 11'h3c5; // Arbitrary value.
	localparam logic [106:0] PINS = {8'h96, {11{9'h1a5}}};
	localparam logic [106:0] PRE = {8'h3c, {11{9'h0d2}}} & ~(107'h1 << OE_CELL);
	localparam logic [106:0] PRE_ON = PRE | (107'h1 << OE_CELL);
	logic core_clk, reset_n, core_q_oe, tck, tms, tdi, tdo, tdo_oe, pin_drive_en, q_bus_oe;
	logic [106:0] pin_values, pin_drive_val;
	logic [107:0] dout;
	logic [2:0] cap;
	int mismatches, cmp_count;

	// ============================================================
	// Design, controller model and core clock.
	bsti_top #(.ID_REVISION(REV), .ID_DEVICE(DEV), .ID_VENDOR(VEN)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .pin_values(pin_values), .core_q_oe(core_q_oe),
		.pin_drive_en(pin_drive_en), .pin_drive_val(pin_drive_val), .q_bus_oe(q_bus_oe)
	);
	bsti_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	// Core clock at 5 ns.
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ============================================================
	// Shared helpers.
	task automatic check(input string what, input logic [107:0] seen, input logic [107:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Core outputs need four edges to follow a change, so six leave margin.
	task automatic core_wait(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic check_id();
		ctl.scan_dr(33, 108'h0, dout);
		check("id", dout[32:0], {1'b0, REV, DEV, VEN, 1'b1});
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ============================================================
	// Scenarios.
	task automatic test_reset();
		core_wait(2);
		check("pin_drive_en", pin_drive_en, 1'b0);
		check("cell47", pin_drive_val[OE_CELL], 1'b1);
		check("q_bus_oe", q_bus_oe, 1'b1);
		ctl.steps(8'h00, 1);
		check_id();
		check("tdo_oe idle", tdo_oe, 1'b0);
		$display("reset test done");
	endtask

	task automatic test_bypass();
		ctl.scan_ir(OP_BYPASS, cap);
		check("ir capture", cap[1:0], 2'b01);
		ctl.scan_dr(2, 108'h1, dout);
		check("bypass", dout[1:0], 2'b10);
		$display("bypass test done");
	endtask

	// Pins are held still across the capture edge.
	task automatic test_sample();
		core_wait(1);
		pin_values = PINS;
		ctl.scan_ir(OP_SAMPLE, cap);
		ctl.scan_dr(108, {PRE, 1'b1}, dout);
		check("sample", dout[106:0], PINS);
		check("bsr length", dout[107], 1'b1);
		core_wait(6);
		check("preload", pin_drive_val, PRE);
		check("pin_drive_en", pin_drive_en, 1'b0);
		$display("sample test done");
	endtask

	// The old instruction stays in force until the update state.
	task automatic test_sample_z();
		ctl.scan_ir(OP_SAMPLE_Z, cap);
		core_wait(6);
		check("q_bus_oe z", q_bus_oe, 1'b0);
		ctl.scan_dr(107, {1'b0, PRE}, dout);
		check("sample z", dout[106:0], PINS);
		ctl.steps(8'h03, 4);
		ctl.shift(3, {105'h0, OP_BYPASS}, dout);
		core_wait(6);
		check("q_bus_oe held", q_bus_oe, 1'b0);
		ctl.steps(8'h01, 2);
		core_wait(6);
		check("q_bus_oe back", q_bus_oe, 1'b1);
		$display("sample z test done");
	endtask

	task automatic test_extest();
		ctl.scan_ir(OP_EXTEST, cap);
		core_wait(6);
		check("pin_drive_en", pin_drive_en, 1'b1);
		check("drive val", pin_drive_val, PRE);
		check("q_bus_oe off", q_bus_oe, 1'b0);
		ctl.scan_dr(107, {1'b0, PRE_ON}, dout);
		check("extest capture", dout[106:0], PINS);
		core_wait(6);
		check("drive val on", pin_drive_val, PRE_ON);
		check("q_bus_oe on", q_bus_oe, 1'b1);
		core_q_oe = 1'b0;
		core_wait(6);
		check("q_bus_oe cell", q_bus_oe, 1'b1);
		$display("extest test done");
	endtask

	// Cell 47 is cleared first, so that the preset by the reset state is really seen.
	task automatic test_tlr();
		core_q_oe = 1'b1;
		ctl.scan_dr(107, {1'b0, PRE}, dout);
		core_wait(6);
		check("q_bus_oe cleared", q_bus_oe, 1'b0);
		ctl.tap_reset();
		core_wait(6);
		check("pin_drive_en", pin_drive_en, 1'b0);
		check("cell47", pin_drive_val[OE_CELL], 1'b1);
		check("q_bus_oe", q_bus_oe, 1'b1);
		check_id();
		$display("reset by mode test done");
	endtask

	// ============================================================
	// Main sequence and hang guard.
	initial begin
		mismatches = 0;
		cmp_count = 0;
		reset_n = 1'b0;
		core_q_oe = 1'b1;
		pin_values = '0;
		repeat (16) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		test_reset();
		test_bypass();
		test_sample();
		test_sample_z();
		test_extest();
		test_tlr();
		give_verdict();
	end

	// A run that hangs counts as a mismatch.
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end
endmodule
